//--- core/bms_consts.vh
// Constants for the bit manipulation and shift unit
`ifndef BMS_CONSTS_VH
`define BMS_CONSTS_VH
// Operation codes on opCode
`define BMS_OP_CLRBIT 3'h0
`define BMS_OP_SETBIT 3'h1
`define BMS_OP_SHL 3'h2
`define BMS_OP_LONG_LEFT_SHIFT_OP 3'h3
`define BMS_OP_NIBBLE_LEFT_SHIFT_OP 3'h4
`define BMS_OP_BYTE_LEFT_SHIFT_OP 3'h5
`define BMS_OP_BYTE_RIGHT_SHIFT_OP 3'h6
// Immediate bit number field in the instruction word
`define BMS_IMM_MSB 7
`define BMS_IMM_LSB 4
// Internal cycles per shifted position
`define BMS_WORD_STEP 2'h1
`define BMS_LONG_STEP 2'h2
// Status word bit positions
`define BMS_ST_Z 3
`define BMS_ST_N 2
`define BMS_ST_C 1
`define BMS_ST_V 0
`endif

//--- core/bms_unit.v
// Bit clear/set and left/right shift execution datapath
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "bms_consts.vh"

// What this block does
// - Clear-bit forces one selected bit to zero
// - Set-bit forces one selected bit to one
// - Bit number from register or instruction bits
// - Byte bit 8-15 rewrites memory byte unchanged
// - Bit instructions leave all four flags
// - Left shift by four-bit count, zero fill
// - Immediate count zero means sixteen positions
// - Long shift uses multiplier word as upper
// - Carry and overflow sticky per step
// - Negative is old sign xor overflow
// - Negative cleared when negative operand overflows
// - Flag width follows operand width
// - Long shift takes two plus 2n cycles
// - Nibble shift moves bits 11-0 up four
// - Nibble shift sets zero, negative from top
// - Byte left shift: low byte to high
// - Byte right shift: high byte to low
// - Byte shifts set zero, clear negative
module bms_unit (
    input wire clk,
    input wire rstn,
    input wire start,
    input wire [2:0] opCode,
    input wire immForm,
    input wire byteForm,
    input wire [15:0] instrWord,
    input wire [15:0] srcReg,
    input wire [15:0] dstReg,
    input wire [15:0] multiplierUpperWord,
    input wire [15:0] dispAddr,
    input wire [3:0] statusIn,
    input wire memRdValid,
    input wire [7:0] memRdData,
    output reg busy,
    output reg done,
    output reg [15:0] resultWord,
    output reg [15:0] resultUpper,
    output reg writeDst,
    output reg writeUpper,
    output reg [3:0] statusWord,
    output reg memRd,
    output reg memWr,
    output reg [15:0] memAddr,
    output reg [7:0] memWrData
);

// ------------------------------------------------------------
// State and working registers
// ------------------------------------------------------------
localparam ST_IDLE = 3'h0;
localparam ST_SHIFT = 3'h1;
localparam ST_MRD = 3'h2;
localparam ST_MWAIT = 3'h3;
localparam ST_MWR = 3'h4;

reg [2:0] state;
reg [31:0] acc;
reg [4:0] remain;
reg [1:0] phase;
reg isLong;
reg signOld;
reg carryAcc;
reg ovfAcc;
reg [3:0] bitSel;
reg isSet;
reg [3:0] heldStatus;

// Bit number selection, register low nibble or immediate field
wire [3:0] selNum = immForm ? instrWord[`BMS_IMM_MSB:`BMS_IMM_LSB] : srcReg[3:0];
// Shift count, immediate zero encodes sixteen
wire [4:0] shCount = (immForm && instrWord[`BMS_IMM_MSB:`BMS_IMM_LSB] == 4'h0) ?
    5'h10 : {1'b0, selNum};

// ------------------------------------------------------------
// Operation decode
// ------------------------------------------------------------
wire opIsSet = (opCode == `BMS_OP_SETBIT);
wire opIsLong = (opCode == `BMS_OP_LONG_LEFT_SHIFT_OP);
wire opIsLeftByte = (opCode == `BMS_OP_BYTE_LEFT_SHIFT_OP);

// Single doubling step over the active width
wire accTop = isLong ? acc[31] : acc[15];
wire accNext = isLong ? acc[30] : acc[14];
wire [31:0] accShift = {acc[30:0], 1'b0};

// Fixed shift results, taken straight from the source register
wire [15:0] nibRes = {srcReg[11:0], 4'h0};
wire [15:0] bl8Res = {srcReg[7:0], 8'h00};
wire [15:0] br8Res = {8'h00, srcReg[15:8]};
wire [15:0] byteRes = opIsLeftByte ? bl8Res : br8Res;

// ------------------------------------------------------------
// Flag terms
// ------------------------------------------------------------
wire nibZero = (nibRes == 16'h0000);
wire byteZero = (byteRes == 16'h0000);
// Zero test covers only the operand width, so word shifts ignore acc[31:16]
wire accZero = isLong ? (acc == 32'h00000000) : (acc[15:0] == 16'h0000);
wire [1:0] stepLen = isLong ? `BMS_LONG_STEP : `BMS_WORD_STEP;
// Word shifts step every cycle, long shifts every second cycle
wire stepEnd = (phase == (stepLen - 2'h1));

// ------------------------------------------------------------
// Per-bit modify for the bit instructions
// ------------------------------------------------------------
wire [15:0] wordBitRes;
wire [7:0] byteMod;
genvar gi;
generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_bit
        localparam [3:0] POS = gi;
        // Only the selected position takes the new value
        assign wordBitRes[gi] = (selNum == POS) ? opIsSet :
            dstReg[gi];
        if (gi < 8) begin : g_byte
            // Numbers 8-15 never match here, so the byte goes back as read
            assign byteMod[gi] = (bitSel == POS) ? isSet : memRdData[gi];
        end
    end
endgenerate

// ------------------------------------------------------------
// Next values
// ------------------------------------------------------------
reg [2:0] next_state;
reg [31:0] next_acc;
reg [4:0] next_remain;
reg [1:0] next_phase;
reg next_isLong;
reg next_signOld;
reg next_carryAcc;
reg next_ovfAcc;
reg [3:0] next_bitSel;
reg next_isSet;
reg [3:0] next_heldStatus;
reg next_busy;
reg next_done;
reg [15:0] next_resultWord;
reg [15:0] next_resultUpper;
reg next_writeDst;
reg next_writeUpper;
reg [3:0] next_statusWord;
reg next_memRd;
reg next_memWr;
reg [15:0] next_memAddr;
reg [7:0] next_memWrData;

// ------------------------------------------------------------
// Sequencer
// ------------------------------------------------------------
always @* begin
    // Data registers hold by default; strobes fall back to low every cycle
    next_state = state;
    next_acc = acc;
    next_remain = remain;
    next_phase = phase;
    next_isLong = isLong;
    next_signOld = signOld;
    next_carryAcc = carryAcc;
    next_ovfAcc = ovfAcc;
    next_bitSel = bitSel;
    next_isSet = isSet;
    next_heldStatus = heldStatus;
    next_busy = busy;
    next_resultWord = resultWord;
    next_resultUpper = resultUpper;
    next_statusWord = statusWord;
    next_memAddr = memAddr;
    next_memWrData = memWrData;
    next_done = 1'b0;
    next_writeDst = 1'b0;
    next_writeUpper = 1'b0;
    next_memRd = 1'b0;
    next_memWr = 1'b0;
    case (state)
        ST_IDLE: begin
            if (start) begin
                next_heldStatus = statusIn;
                case (opCode)
                    `BMS_OP_CLRBIT, `BMS_OP_SETBIT: begin
                        if (byteForm) begin
                            next_bitSel = selNum;
                            next_isSet = opIsSet;
                            next_memAddr = dispAddr;
                            next_memRd = 1'b1;
                            next_busy = 1'b1;
                            next_state = ST_MWAIT;
                        end else begin
                            next_resultWord = wordBitRes;
                            next_writeDst = 1'b1;
                            next_statusWord = statusIn;
                            next_done = 1'b1;
                        end
                    end
                    `BMS_OP_SHL, `BMS_OP_LONG_LEFT_SHIFT_OP: begin
                        // Long form treats the multiplier word as the upper half
                        next_isLong = opIsLong;
                        if (opIsLong) begin
                            next_acc = {multiplierUpperWord, dstReg};
                            next_signOld = multiplierUpperWord[15];
                        end else begin
                            next_acc = {16'h0000, dstReg};
                            next_signOld = dstReg[15];
                        end
                        next_carryAcc = 1'b0;
                        next_ovfAcc = 1'b0;
                        next_remain = shCount;
                        next_phase = 2'h0;
                        next_busy = 1'b1;
                        next_state = ST_SHIFT;
                    end
                    `BMS_OP_NIBBLE_LEFT_SHIFT_OP: begin
                        next_resultWord = nibRes;
                        next_writeDst = 1'b1;
                        next_statusWord = statusIn;
                        next_statusWord[`BMS_ST_Z] = nibZero;
                        next_statusWord[`BMS_ST_N] = nibRes[15];
                        next_done = 1'b1;
                    end
                    `BMS_OP_BYTE_LEFT_SHIFT_OP, `BMS_OP_BYTE_RIGHT_SHIFT_OP: begin
                        next_resultWord = byteRes;
                        next_writeDst = 1'b1;
                        next_statusWord = statusIn;
                        next_statusWord[`BMS_ST_Z] = byteZero;
                        next_statusWord[`BMS_ST_N] = 1'b0;
                        next_done = 1'b1;
                    end
                    default: begin
                        // Unused code finishes at once and keeps the flags
                        next_statusWord = statusIn;
                        next_done = 1'b1;
                    end
                endcase
            end
        end
        ST_SHIFT: begin
            // Long shifts idle one extra cycle per position
            if (stepEnd) begin
                next_phase = 2'h0;
                if (remain != 5'h00) begin
                    next_acc = accShift;
                    next_carryAcc = carryAcc | accTop;
                    next_ovfAcc = ovfAcc | (accTop ^ accNext);
                    next_remain = remain - 5'h01;
                end else begin
                    next_resultWord = acc[15:0];
                    next_resultUpper = acc[31:16];
                    next_writeDst = 1'b1;
                    next_writeUpper = isLong;
                    next_statusWord[`BMS_ST_Z] = accZero;
                    next_statusWord[`BMS_ST_N] = signOld ^ ovfAcc;
                    next_statusWord[`BMS_ST_C] = carryAcc;
                    next_statusWord[`BMS_ST_V] = ovfAcc;
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    next_state = ST_IDLE;
                end
            end else begin
                next_phase = phase + 2'h1;
            end
        end
        ST_MWAIT: begin
            // Partner returns the byte some cycles after the read
            if (memRdValid) begin
                next_memWrData = byteMod;
                next_memWr = 1'b1;
                next_state = ST_MWR;
            end
        end
        ST_MWR: begin
            // Flags come from the copy taken at start, the bus write never touches them
            next_statusWord = heldStatus;
            next_busy = 1'b0;
            next_done = 1'b1;
            next_state = ST_IDLE;
        end
        default: begin
            next_busy = 1'b0;
            next_state = ST_IDLE;
        end
    endcase
end

// ------------------------------------------------------------
// State registers
// ------------------------------------------------------------
// Every output is a flip-flop; the block above only picks next values
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        state <= ST_IDLE;
        acc <= 32'h00000000;
        remain <= 5'h00;
        phase <= 2'h0;
        isLong <= 1'b0;
        signOld <= 1'b0;
        carryAcc <= 1'b0;
        ovfAcc <= 1'b0;
        bitSel <= 4'h0;
        isSet <= 1'b0;
        heldStatus <= 4'h0;
        busy <= 1'b0;
        done <= 1'b0;
        resultWord <= 16'h0000;
        resultUpper <= 16'h0000;
        writeDst <= 1'b0;
        writeUpper <= 1'b0;
        statusWord <= 4'h0;
        memRd <= 1'b0;
        memWr <= 1'b0;
        memAddr <= 16'h0000;
        memWrData <= 8'h00;
    end else begin
        state <= next_state;
        acc <= next_acc;
        remain <= next_remain;
        phase <= next_phase;
        isLong <= next_isLong;
        signOld <= next_signOld;
        carryAcc <= next_carryAcc;
        ovfAcc <= next_ovfAcc;
        bitSel <= next_bitSel;
        isSet <= next_isSet;
        heldStatus <= next_heldStatus;
        busy <= next_busy;
        done <= next_done;
        resultWord <= next_resultWord;
        resultUpper <= next_resultUpper;
        writeDst <= next_writeDst;
        writeUpper <= next_writeUpper;
        statusWord <= next_statusWord;
        memRd <= next_memRd;
        memWr <= next_memWr;
        memAddr <= next_memAddr;
        memWrData <= next_memWrData;
    end
end

endmodule // bms_unit

//--- dv/bms_unit_monitor.sv
// Port-level checks for the bit and shift unit
`timescale 1ns/1ps
module bms_unit_monitor (
    input wire clk, input wire rstn, input wire start, input wire immForm,
    input wire byteForm, input wire [2:0] opCode, input wire [15:0] instrWord,
    input wire [15:0] srcReg, input wire [15:0] dstReg, input wire [3:0] statusIn,
    input wire memRdValid, input wire busy, input wire done, input wire memRd,
    input wire memWr, input wire [15:0] resultWord, input wire [3:0] statusWord
);
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
wire go = start && !busy;
wire rb = go && !byteForm && opCode < 3'h2;
wire [15:0] msk = 16'h0001 << (immForm ? instrWord[7:4] : srcReg[3:0]);
property p_clr; rb && opCode == 3'h0 |=>
    done && resultWord == ($past(dstReg) & ~$past(msk)); endproperty
a_clr: assert property (p_clr) else $error("clear bit");
property p_set; rb && opCode == 3'h1 |=> resultWord == ($past(dstReg) | $past(msk)); endproperty
a_set: assert property (p_set) else $error("set bit");
property p_flg; rb |=> statusWord == $past(statusIn); endproperty
a_flg: assert property (p_flg) else $error("bit op flags");
property p_nib; go && opCode == 3'h4 |=> resultWord == {$past(srcReg[11:0]), 4'h0}; endproperty
a_nib: assert property (p_nib) else $error("nibble shift");
property p_nom; rb || (go && opCode > 3'h3) |=> !memRd && !memWr; endproperty
a_nom: assert property (p_nom) else $error("memory touched");
property p_rmw; memRdValid && busy |=> memWr ##1 done; endproperty
a_rmw: assert property (p_rmw) else $error("write back");
property p_mrd; go && byteForm && opCode < 3'h2 |=> memRd && busy; endproperty
a_mrd: assert property (p_mrd) else $error("byte read");
property p_lng; go && opCode == 3'h3 && immForm && instrWord[7:4] == 4'h1 |-> ##5 done;
endproperty
a_lng: assert property (p_lng) else $error("long shift time");
property p_z16; go && opCode == 3'h2 && immForm && instrWord[7:4] == 4'h0 |->
    ##18 done && resultWord == 16'h0000; endproperty
a_z16: assert property (p_z16) else $error("count zero shift");
endmodule // bms_unit_monitor
bind bms_unit bms_unit_monitor mon (.*);

//--- dv/bms_mem_model.sv
// Data memory bus partner answering byte reads
`timescale 1ns/1ps
module bms_mem_model (
    input wire clk, input wire rstn, input wire slow, input wire memRd, input wire memWr,
    input wire [15:0] memAddr, input wire [7:0] memWrData, output reg memRdValid,
    output reg [7:0] memRdData, output reg [15:0] wrAddr, output reg [7:0] wrData
);
reg [2:0] wt;
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        {memRdValid, memRdData, wt, wrAddr, wrData} <= 36'h0;
    end else begin
        memRdValid <= wt == 3'h1;
        // Idle bus toggles so a stale byte is never mistaken for data
        memRdData <= (wt == 3'h1) ? memAddr[15:8] ^ memAddr[7:0] : ~memRdData;
        wt <= memRd ? (slow ? 3'h4 : 3'h1) : wt - {2'b00, wt != 3'h0};
        if (memWr) {wrAddr, wrData} <= {memAddr, memWrData};
    end
end
endmodule // bms_mem_model

//--- dv/bms_unit_tb.sv
// Self-checking bench for the bit and shift unit
`timescale 1ns/1ps
module bms_unit_tb;
reg clk = 1'b0, rstn = 1'b0, start = 1'b0, immForm = 1'b0, byteForm = 1'b0, slow = 1'b0;
reg [2:0] opCode = 3'h0;
reg [15:0] instrWord = 16'h0000, srcReg = 16'h0000, dstReg = 16'h0000, dispAddr = 16'h0000;
reg [15:0] multiplierUpperWord = 16'h0000;
reg [3:0] statusIn = 4'h0;
reg [31:0] seed = 32'h00006505;
wire memRdValid, busy, done, writeDst, writeUpper, memRd, memWr;
wire [7:0] memRdData, memWrData, wrData;
wire [15:0] resultWord, resultUpper, memAddr, wrAddr;
wire [3:0] statusWord;
integer err_total = 0, tests_run = 0, cyc = 0;
bms_unit dut (.*);
bms_mem_model mem (.*);
always #2.5 clk = ~clk;
function [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
endfunction
task chk(input [63:0] seen, input [63:0] exp, input string what);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
endtask
task summarize;
    if (cyc >= 12000) err_total = err_total + 1;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
// Repeated doubling, so sticky flags fall out of the loop
function [35:0] calc(input [2:0] op, input [15:0] s, d, u, input [3:0] st, input integer k);
    reg [31:0] v;
    reg c, o;
    integer i, w;
    w = op[0] ? 31 : 15;
    v = op[0] ? {u, d} : {16'h0000, d};
    {c, o} = 2'b00;
    for (i = 0; i < k; i = i + 1) begin
        c = c | v[w];
        o = o | (v[w] ^ v[w - 1]);
        v = v << 1;
    end
    if (!op[0]) v[31:16] = 16'h0000;
    calc = {v == 32'h0, (op[0] ? u[15] : d[15]) ^ o, c, o, v};
    case (op)
        3'h0: calc = {st, 16'h0000, d & ~(16'h0001 << k)};
        3'h1: calc = {st, 16'h0000, d | (16'h0001 << k)};
        3'h4: calc = {s[11:0] == 12'h000, s[11], st[1:0], 16'h0000, s[11:0], 4'h0};
        3'h5: calc = {s[7:0] == 8'h00, 1'b0, st[1:0], 16'h0000, s[7:0], 8'h00};
        3'h6: calc = {s[15:8] == 8'h00, 1'b0, st[1:0], 24'h000000, s[15:8]};
        default: ;
    endcase
endfunction
task run(input [2:0] op, input im, input bf, input [3:0] n);
    reg [15:0] s, iw, d, u, a;
    reg [3:0] st;
    reg [7:0] m;
    {s, iw} = rnd();
    {u, d} = rnd();
    {a, st, m, m[3:0]} = rnd();
    if (!im) s[3:0] = n;
    iw[7:4] = n;
    m = a[15:8] ^ a[7:0];
    if (n < 4'h8) m[n[2:0]] = op[0];
    @(posedge clk);
    {start, opCode, immForm, byteForm, srcReg, instrWord} <= {1'b1, op, im, bf, s, iw};
    {dstReg, multiplierUpperWord, dispAddr, statusIn, slow} <= {d, u, a, st, iw[0]};
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    repeat (60) if (done !== 1'b1) @(negedge clk);
    chk({writeDst, writeUpper}, {!bf, !bf && op == 3'h3}, "write strobes");
    if (bf)
        chk({wrAddr, wrData, statusWord}, {a, m, st}, "byte write");
    else
        chk({statusWord, op == 3'h3 ? resultUpper : 16'h0000, resultWord},
            calc(op, s, d, u, st, (im && n == 4'h0 && op[2:1] == 2'b01) ? 16 : n), "result");
    $display("test op %0d count %0d ends", op, n);
endtask
initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    run(3'h2, 1'b1, 1'b0, 4'h0);
    run(3'h3, 1'b1, 1'b0, 4'h1);
    run(3'h3, 1'b0, 1'b0, 4'hF);
    run(3'h0, 1'b1, 1'b1, 4'h9);
    repeat (80) run(seed[2:0] % 3'h7, seed[3], seed[4] && seed[2:0] < 3'h2, seed[8:5]);
    summarize;
end
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) summarize;
end
endmodule // bms_unit_tb
